// [include/cfg_cmd_pkg.sv]
`default_nettype none
package cfg_cmd_pkg;
  // Command codes
  localparam logic [7:0] CODE_SAVE = 8'h46;
  localparam logic [7:0] CODE_STARTUP = 8'h47;
  localparam logic [7:0] CODE_STATUS = 8'h43;
  // Defined payload lengths
  localparam logic [7:0] LEN_SAVE = 8'h01;
  localparam logic [7:0] LEN_STARTUP = 8'h01;
  localparam logic [7:0] LEN_STATUS = 8'h02;
  // Set identifiers
  localparam logic [7:0] SET_FACTORY = 8'h00;
  localparam logic [7:0] SET_USER_MIN = 8'h01;
  localparam logic [7:0] SET_USER_MAX = 8'h0f;
  localparam logic [7:0] STARTUP_RESET = 8'h00;
  // Status byte 1 bit positions
  localparam int BIT_NO_SYNC = 0;
  localparam int BIT_RESET_SEEN = 1;
  localparam int BIT_UNLOCKED = 2;
  localparam int BIT_RSVD = 3;
  localparam int BIT_UNKNOWN = 4;
  localparam int BIT_DENIED = 5;
  localparam int BIT_BAD_LEN = 6;
  localparam int BIT_PARAM = 7;
  // Trigger timeout
  localparam int SYNC_TIMEOUT_S = 5;
  localparam int CLK_HZ = 125_000_000;
  localparam int SYNC_TIMEOUT_CYC = SYNC_TIMEOUT_S * CLK_HZ;
  localparam int TIMER_W = 32;

  // Incoming decoded command frame
  typedef struct packed {
    logic [7:0] command_code;
    logic rd; // 1 = read request
    logic [7:0] len;
    logic [7:0] data;
  } cmd_frame_t;

  // Outgoing response frame
  typedef struct packed {
    logic [7:0] command_code;
    logic rd;
    logic [7:0] len;
    logic [7:0] byte1;
    logic [7:0] byte2;
  } rsp_frame_t;
endpackage
`default_nettype wire

// [rtl/cfg_set_status.sv]
`default_nettype none
module cfg_set_status #(
  parameter int unsigned SYNC_TIMEOUT_CYC = cfg_cmd_pkg::SYNC_TIMEOUT_CYC
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic i_cmd_valid,
  input wire cfg_cmd_pkg::cmd_frame_t i_cmd,
  input wire logic i_external_sync_trigger,
  input wire logic i_unlocked,
  input wire logic [7:0] i_dev_errors,
  output logic o_rsp_valid,
  output cfg_cmd_pkg::rsp_frame_t o_rsp,
  output logic o_save_valid,
  output logic [7:0] o_save_slot,
  output logic [7:0] o_startup_sel
);

  if (SYNC_TIMEOUT_CYC < 1 || SYNC_TIMEOUT_CYC > 32'hffff_fffe)
  begin : g_bad_timeout
    $error("SYNC_TIMEOUT_CYC out of range");
  end

  // Pin synchronisers: three stages, change accepted when last two agree
  logic [2:0] sync_pin_ff;
  logic [2:0] lock_pin_ff;
  logic sync_lvl_ff;
  logic unlocked_ff;
  logic [cfg_cmd_pkg::TIMER_W-1:0] timer_ff;
  logic no_sync_ff;
  logic reset_seen_ff;
  logic unknown_ff;
  logic denied_ff;
  logic bad_len_ff;

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      sync_pin_ff <= 3'h0;
      lock_pin_ff <= 3'h0;
    end
    else if (i_ce)
    begin
      sync_pin_ff <= {sync_pin_ff[1:0], i_external_sync_trigger};
      lock_pin_ff <= {lock_pin_ff[1:0], i_unlocked};
    end
  end

  // Filtered levels and trigger edge
  wire sync_agree = sync_pin_ff[1] == sync_pin_ff[2];
  wire lock_agree = lock_pin_ff[1] == lock_pin_ff[2];
  wire sync_edge = sync_agree && sync_pin_ff[2] && !sync_lvl_ff;

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      sync_lvl_ff <= 1'b0;
      unlocked_ff <= 1'b0;
    end
    else if (i_ce)
    begin
      if (sync_agree) sync_lvl_ff <= sync_pin_ff[2];
      if (lock_agree) unlocked_ff <= lock_pin_ff[2];
    end
  end

  // Trigger watchdog: flag once the timeout passes without an edge
  wire timer_done = timer_ff >= cfg_cmd_pkg::TIMER_W'(SYNC_TIMEOUT_CYC - 1);
  wire [cfg_cmd_pkg::TIMER_W-1:0] nxt_timer =
    sync_edge ? '0 : (timer_done ? timer_ff : timer_ff + 1'b1);

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      timer_ff <= '0;
      no_sync_ff <= 1'b0;
    end
    else if (i_ce)
    begin
      timer_ff <= nxt_timer;
      no_sync_ff <= !sync_edge && timer_done;
    end
  end

  // Command decode
  wire is_save = i_cmd.command_code == cfg_cmd_pkg::CODE_SAVE;
  wire is_start = i_cmd.command_code == cfg_cmd_pkg::CODE_STARTUP;
  wire is_stat = i_cmd.command_code == cfg_cmd_pkg::CODE_STATUS;
  wire take = i_ce && i_cmd_valid;
  wire known = is_save || is_start || is_stat;
  wire len_ok = is_save ? i_cmd.len == cfg_cmd_pkg::LEN_SAVE :
    is_start ? i_cmd.len == cfg_cmd_pkg::LEN_STARTUP :
    i_cmd.len == cfg_cmd_pkg::LEN_STATUS;
  wire user_id = i_cmd.data >= cfg_cmd_pkg::SET_USER_MIN &&
    i_cmd.data <= cfg_cmd_pkg::SET_USER_MAX;
  wire start_id = user_id || i_cmd.data == cfg_cmd_pkg::SET_FACTORY;
  // Wrong direction: read of a save, write of status
  wire deny = (is_save && i_cmd.rd) || (is_stat && !i_cmd.rd);
  wire ok = take && known && len_ok && !deny;
  wire do_save = ok && is_save && user_id;
  wire do_sel_wr = ok && is_start && !i_cmd.rd && start_id;
  wire do_sel_rd = ok && is_start && i_cmd.rd;
  wire do_stat = ok && is_stat;
  wire ev_unknown = take && !known;
  wire ev_bad_len = take && known && !len_ok;
  wire ev_denied = take && known && len_ok && deny;

  // Status byte 1: live conditions plus sticky events
  wire [7:0] stat_b1 = {1'b0, bad_len_ff, denied_ff, unknown_ff, 1'b0,
    unlocked_ff, reset_seen_ff, no_sync_ff};

  // Sticky event flags, cleared by a status read; a new event wins
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      reset_seen_ff <= 1'b1;
      unknown_ff <= 1'b0;
      denied_ff <= 1'b0;
      bad_len_ff <= 1'b0;
    end
    else if (i_ce)
    begin
      reset_seen_ff <= reset_seen_ff && !do_stat;
      unknown_ff <= ev_unknown || (unknown_ff && !do_stat);
      denied_ff <= ev_denied || (denied_ff && !do_stat);
      bad_len_ff <= ev_bad_len || (bad_len_ff && !do_stat);
    end
  end

  // Startup selector and save strobe
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_startup_sel <= cfg_cmd_pkg::STARTUP_RESET;
      o_save_valid <= 1'b0;
      o_save_slot <= 8'h00;
    end
    else if (i_ce)
    begin
      if (do_sel_wr) o_startup_sel <= i_cmd.data;
      o_save_valid <= do_save;
      if (do_save) o_save_slot <= i_cmd.data;
    end
  end

  // Response frame: only reads are answered; one driver for the whole frame
  wire [7:0] rsp_len = do_stat ? cfg_cmd_pkg::LEN_STATUS : cfg_cmd_pkg::LEN_STARTUP;
  wire [7:0] rsp_b1 = do_stat ? stat_b1 : o_startup_sel;
  wire [7:0] rsp_b2 = do_stat ? i_dev_errors : 8'h00;
  cfg_cmd_pkg::rsp_frame_t nxt_rsp;
  assign nxt_rsp = {i_cmd.command_code, 1'b0, rsp_len, rsp_b1, rsp_b2};

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_rsp_valid <= 1'b0;
      o_rsp <= '0;
    end
    else if (i_ce)
    begin
      o_rsp_valid <= do_sel_rd || do_stat;
      if (do_sel_rd || do_stat) o_rsp <= nxt_rsp;
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);

  chk_save_strobe: assert property (do_save |=> o_save_valid
    && o_save_slot == $past(i_cmd.data))
    else $error("save not issued");
  chk_save_range: assert property (o_save_valid |-> o_save_slot inside {[8'h01:8'h0f]})
    else $error("save slot out of range");
  chk_sel_reject: assert property (take && is_start && !i_cmd.rd && !start_id
    |=> $stable(o_startup_sel))
    else $error("bad selector write accepted");
  chk_sel_write: assert property (do_sel_wr |=> o_startup_sel == $past(i_cmd.data))
    else $error("selector not written");
  chk_sel_read: assert property (do_sel_rd |=> o_rsp_valid
    && o_rsp.command_code == cfg_cmd_pkg::CODE_STARTUP
    && o_rsp.byte1 == $past(o_startup_sel) && o_rsp.len == cfg_cmd_pkg::LEN_STARTUP)
    else $error("selector read answer wrong");
  chk_write_silent: assert property (take && !i_cmd.rd |=> !o_rsp_valid)
    else $error("write answered");
  chk_stat_answer: assert property (do_stat |=> o_rsp_valid && !o_rsp.rd
    && o_rsp.len == cfg_cmd_pkg::LEN_STATUS && o_rsp.byte1[3] == 1'b0)
    else $error("status answer wrong");
  chk_unknown_flag: assert property (ev_unknown |=> unknown_ff)
    else $error("unknown code not flagged");
  chk_len_flag: assert property (ev_bad_len |=> bad_len_ff
    && !o_rsp_valid && !o_save_valid)
    else $error("length error not flagged");
  chk_sync_clear: assert property (i_ce && sync_edge |=> !no_sync_ff)
    else $error("sync edge did not clear timeout");

  cov_save: cover property (do_save ##1 o_save_valid);
  cov_sel_rw: cover property (do_sel_wr ##[1:20] do_sel_rd);
  cov_stat: cover property (ev_unknown ##[1:20] do_stat);
  cov_timeout: cover property (!no_sync_ff ##1 no_sync_ff);

endmodule
`default_nettype wire

// [tb/config_set_and_status_commands_bench.sv]
`default_nettype none
module config_set_and_status_commands_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic go = 1'b0;
  logic trig = 1'b0;
  logic unl = 1'b1;
  logic sync_run = 1'b1;
  logic ce = 1'b1;
  logic [7:0] errs = 8'h00;
  logic valid, rsp_valid, save_valid;
  logic [7:0] save_slot, sel, v;
  logic [7:0] exp_sel = 8'h00;
  logic [7:0] exp_slot = 8'h00;
  logic [7:0] corner [4] = '{8'h00, 8'h0f, 8'h10, 8'h01};
  cfg_cmd_pkg::cmd_frame_t frame = '0;
  cfg_cmd_pkg::cmd_frame_t cmd;
  cfg_cmd_pkg::rsp_frame_t rsp;
  int n_fail = 0;
  int num_checks = 0;
  int seed = 32'hbabd010e;
  int k = 0;

  always #4 clk = ~clk;
  // Trigger pin toggles every 10 cycles while enabled
  always @(negedge clk)
  begin
    k++;
    if (sync_run && k % 10 == 0)
      trig = ~trig;
  end

  host_link_model host (.i_go(go), .i_frame(frame), .o_valid(valid), .o_cmd(cmd));

  cfg_set_status #(.SYNC_TIMEOUT_CYC(50)) DUT (
    .i_clk(clk), .i_rstn(rstn), .i_ce(ce), .i_cmd_valid(valid), .i_cmd(cmd),
    .i_external_sync_trigger(trig), .i_unlocked(unl), .i_dev_errors(errs),
    .o_rsp_valid(rsp_valid), .o_rsp(rsp), .o_save_valid(save_valid),
    .o_save_slot(save_slot), .o_startup_sel(sel)
  );

  // Expected answer frame, direction always zero
  function automatic logic [33:0] exp_rsp(input logic [7:0] c, l, b1, b2);
    return {1'b1, c, 1'b0, l, b1, b2};
  endfunction

  // Set identifier within lo..0x0f
  function automatic logic id_ok(input logic [7:0] id, input logic [7:0] lo);
    return id >= lo && id <= 8'h0f;
  endfunction

  task automatic chk(input string nm, input logic [39:0] got, input logic [39:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic stop_test();
    if (n_fail == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // One frame, returns in the cycle after the taking edge
  task automatic send(input logic [7:0] c, input logic r, input logic [7:0] l, d);
    @(negedge clk);
    frame = '{c, r, l, d};
    go = 1'b1;
    @(negedge clk);
    go = 1'b0;
  endtask

  task automatic status(input logic [7:0] b1);
    errs = 8'($random(seed));
    send(8'h43, 1'b1, 8'h02, 8'h00);
    chk("status", {rsp_valid, rsp}, exp_rsp(8'h43, 8'h02, b1, errs));
  endtask

  // Watchdog
  initial
  begin
    repeat (5000) @(posedge clk);
    n_fail++;
    stop_test();
  end

  initial
  begin
    repeat (8) @(negedge clk);
    rstn = 1'b1;
    repeat (6) @(negedge clk);
    status(8'h06);
    status(8'h04);
    unl = 1'b0;
    repeat (6) @(negedge clk);
    v = 8'($random(seed));
    if (v inside {8'h43, 8'h46, 8'h47})
      v = 8'h00;
    send(v, 1'b1, 8'h01, 8'h00);
    chk("unknown rsp", rsp_valid, 1'b0);
    send(8'h46, 1'b0, 8'h02, 8'h03);
    chk("bad len save", save_valid, 1'b0);
    send(8'h43, 1'b0, 8'h02, 8'h00);
    chk("status write", rsp_valid, 1'b0);
    status(8'h70);
    status(8'h00);
    sync_run = 1'b0;
    repeat (64) @(negedge clk);
    status(8'h01);
    sync_run = 1'b1;
    repeat (30) @(negedge clk);
    status(8'h00);
    // Corner identifiers first, then random ones
    for (int i = 0; i < 24; i++)
    begin
      v = (i < 4) ? corner[i] : 8'($random(seed)) & 8'h1f;
      send(8'h46, 1'b0, 8'h01, v);
      if (id_ok(v, 8'h01))
        exp_slot = v;
      chk("save strobe", {rsp_valid, save_valid}, {1'b0, id_ok(v, 8'h01)});
      chk("save slot", save_slot, exp_slot);
      send(8'h47, 1'b0, 8'h01, v);
      if (id_ok(v, 8'h00))
        exp_sel = v;
      chk("sel write", {rsp_valid, sel}, {1'b0, exp_sel});
      send(8'h47, 1'b1, 8'h01, 8'h00);
      chk("sel read", {rsp_valid, rsp}, exp_rsp(8'h47, 8'h01, exp_sel, 8'h00));
    end
    // Enable low: a selector write must leave no trace
    ce = 1'b0;
    send(8'h47, 1'b0, 8'h01, ~exp_sel & 8'h0f);
    chk("frozen sel", sel, exp_sel);
    ce = 1'b1;
    // Reset in mid-run: selector back to factory, reset flag raised again
    rstn = 1'b0;
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    exp_sel = 8'h00;
    chk("sel after reset", sel, exp_sel);
    repeat (6) @(negedge clk);
    status(8'h02);
    stop_test();
  end
endmodule
`default_nettype wire

// [tb/host_link_model.sv]
`default_nettype none
// Host side of the command link: frames are only valid while requested
module host_link_model (
  input wire logic i_go,
  input wire cfg_cmd_pkg::cmd_frame_t i_frame,
  output logic o_valid,
  output cfg_cmd_pkg::cmd_frame_t o_cmd
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus shows the inverse of the last frame, never a stale copy
  assign o_valid = i_go;
  assign o_cmd = i_go ? i_frame : ~i_frame;
endmodule
`default_nettype wire
